// ==== design/strand_halt_pkg.sv ====
// Shared constants and types for the strand halt and wake block
package strand_halt_pkg;
  localparam int unsigned DATA_W = 64;
  localparam int unsigned HPR_ADDR_W = 5;
  // Hyperprivileged register numbers
  localparam logic [4:0] SLEEP_REQ_ADDR = 5'h1e;
  localparam logic [4:0] TICK_CMP_ADDR = 5'h1f;
  localparam logic [63:0] SLEEP_REQ_RESET = 64'h0;
  // Tick compare register layout
  localparam int unsigned CMP_INT_DIS_BIT = 63;
  localparam int unsigned CMP_VAL_W = 63;
  localparam int unsigned CMP_IGNORE_W = 7;
  localparam logic [63:0] TICK_CMP_RESET = 64'h8000_0000_0000_0000;
  localparam logic [6:0] TICK_LOW_ONES = 7'h7f;
  // Soft interrupt bits set by tick matches
  localparam int unsigned SOFTINT_TM_BIT = 0;
  localparam int unsigned SOFTINT_SM_BIT = 16;
  localparam int unsigned SOFTINT_W = 17;
  typedef enum logic [1:0] {
    ST_DISABLED,
    ST_PARKED,
    ST_RUNNING,
    ST_HALTED
  } strand_state_t;
endpackage : strand_halt_pkg

// ==== design/tick_cmp_if.sv ====
// Interface between the register file and the tick compare unit
`timescale 1ns/1ps
interface tick_cmp_if;
  logic [62:0] cmp_val;
  logic int_dis;
  logic match;
  modport regs (output cmp_val, output int_dis, input match);
  modport cmp (input cmp_val, input int_dis, output match);
endinterface : tick_cmp_if

// ==== design/tick_compare.sv ====
// Tick compare unit: matches counter against compare value, low bits ignored
`timescale 1ns/1ps
module tick_compare (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Counter
  input wire logic [62:0] stick_cnt,
  // Compare register side
  tick_cmp_if.cmp cif
);
  logic hit;
  logic hit_q;
  // Upper-bit equality, low seven bits excluded
  assign hit = (stick_cnt[62:strand_halt_pkg::CMP_IGNORE_W]
               == cif.cmp_val[62:strand_halt_pkg::CMP_IGNORE_W]);
  // Edge of equality gives one match pulse
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= hit;
    end
  end
  assign cif.match = hit && !hit_q && !cif.int_dis;
endmodule : tick_compare

// ==== design/strand_halt_wake.sv ====
// Per-strand halt and wake control with tick compare register
`timescale 1ns/1ps
module strand_halt_wake (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Hyperprivileged register access
  input wire logic hpr_wr,
  input wire logic hpr_rd,
  input wire logic [4:0] hpr_addr,
  input wire logic [63:0] hpr_wdata,
  output logic [63:0] hpr_rdata,
  output logic hpr_rvalid,
  // Tick counters
  input wire logic [62:0] stick_cnt,
  input wire logic stick_rd,
  output logic [63:0] stick_rdata,
  input wire logic tick_match,
  // Strand control
  input wire logic strand_enable,
  input wire logic park_req,
  input wire logic [63:0] halt_npc,
  // Wake sources
  input wire logic xstrand_intr,
  input wire logic vector_intr,
  input wire logic external_reset_request,
  input wire logic error_event,
  input wire logic intr_pending,
  input wire logic single_step_mode,
  input wire logic disable_overlap_mode,
  // Status
  output logic [1:0] strand_state,
  output logic issue_en,
  output logic resume_valid,
  output logic [63:0] next_instruction_address,
  output logic [16:0] softint,
  output logic hyper_pending,
  output logic [63:0] tick_cmp_reg
);
  strand_halt_pkg::strand_state_t state_q, state_d;
  logic [62:0] cmp_val_q;
  logic int_dis_q;
  logic [16:0] softint_q;
  logic hintp_q;
  logic step_q, ovl_q;
  logic [63:0] npc_q;
  logic resume_q;
  logic issue_q;
  logic [63:0] rdata_q;
  logic rvalid_q;
  logic [63:0] stick_rdata_q;
  logic sys_match;
  tick_cmp_if cif ();

  // Compare unit instance
  tick_compare u_cmp (
    .mclk(mclk),
    .rst_b(rst_b),
    .stick_cnt(stick_cnt),
    .cif(cif)
  );
  assign cif.cmp_val = cmp_val_q;
  assign cif.int_dis = int_dis_q;
  assign sys_match = cif.match;

  // Decode of hyperprivileged accesses
  wire sleep_wr = hpr_wr && (hpr_addr == strand_halt_pkg::SLEEP_REQ_ADDR);
  wire cmp_wr = hpr_wr && (hpr_addr == strand_halt_pkg::TICK_CMP_ADDR);
  wire cmp_rd = hpr_rd && (hpr_addr == strand_halt_pkg::TICK_CMP_ADDR);
  wire step_entry = single_step_mode && !step_q;
  wire ovl_entry = disable_overlap_mode && !ovl_q;
  // Hyper tick match sets pending flag; interrupt-disable gates it
  wire hyper_set = sys_match;
  // Anything that would interrupt or block halting
  wire softint_block = softint_q[strand_halt_pkg::SOFTINT_SM_BIT]
                       || softint_q[strand_halt_pkg::SOFTINT_TM_BIT];
  wire intr_now = xstrand_intr || vector_intr || external_reset_request
                  || error_event || intr_pending || tick_match || sys_match;
  wire halt_blocked = softint_block || hintp_q || intr_now
                      || single_step_mode || disable_overlap_mode;
  // Wake events for a halted strand; no priority or error mask applied
  wire wake = xstrand_intr || vector_intr
              || external_reset_request
              || error_event
              || tick_match || sys_match || softint_block || hintp_q
              || step_entry || ovl_entry
              || park_req;

  // Next strand state
  always_comb begin
    state_d = state_q;
    case (state_q)
      strand_halt_pkg::ST_DISABLED: begin
        if (strand_enable) state_d = park_req ? strand_halt_pkg::ST_PARKED : strand_halt_pkg::ST_RUNNING;
      end
      strand_halt_pkg::ST_PARKED: begin
        if (!strand_enable) state_d = strand_halt_pkg::ST_DISABLED;
        else if (!park_req) state_d = strand_halt_pkg::ST_RUNNING;
      end
      strand_halt_pkg::ST_RUNNING: begin
        if (!strand_enable) state_d = strand_halt_pkg::ST_DISABLED;
        else if (park_req) state_d = strand_halt_pkg::ST_PARKED;
        else if (sleep_wr && !halt_blocked) state_d = strand_halt_pkg::ST_HALTED;
      end
      strand_halt_pkg::ST_HALTED: begin
        if (!strand_enable) state_d = strand_halt_pkg::ST_DISABLED;
        else if (wake) state_d = strand_halt_pkg::ST_RUNNING;
      end
      default: state_d = strand_halt_pkg::ST_DISABLED;
    endcase
  end

  // State, mode history and resume address
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= strand_halt_pkg::ST_DISABLED;
      step_q <= 1'b0;
      ovl_q <= 1'b0;
      npc_q <= 64'h0;
      resume_q <= 1'b0;
      issue_q <= 1'b0;
    end else begin
      issue_q <= (state_d == strand_halt_pkg::ST_RUNNING);
      state_q <= state_d;
      step_q <= single_step_mode;
      ovl_q <= disable_overlap_mode;
      if (state_q == strand_halt_pkg::ST_RUNNING && state_d == strand_halt_pkg::ST_HALTED) begin
        npc_q <= halt_npc;
      end
      resume_q <= (state_q == strand_halt_pkg::ST_HALTED) && (state_d == strand_halt_pkg::ST_RUNNING);
    end
  end

  // Compare register, soft interrupt and hyper pending flags
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      int_dis_q <= strand_halt_pkg::TICK_CMP_RESET[strand_halt_pkg::CMP_INT_DIS_BIT];
      cmp_val_q <= strand_halt_pkg::TICK_CMP_RESET[62:0];
      softint_q <= 17'h0;
      hintp_q <= 1'b0;
    end else begin
      if (cmp_wr) begin
        int_dis_q <= hpr_wdata[strand_halt_pkg::CMP_INT_DIS_BIT];
        cmp_val_q <= hpr_wdata[62:0];
      end
      // Set wins over software acknowledge
      if (tick_match) softint_q[strand_halt_pkg::SOFTINT_TM_BIT] <= 1'b1;
      else if (intr_pending && state_q == strand_halt_pkg::ST_RUNNING) softint_q[strand_halt_pkg::SOFTINT_TM_BIT] <= 1'b0;
      if (sys_match) softint_q[strand_halt_pkg::SOFTINT_SM_BIT] <= 1'b1;
      else if (intr_pending && state_q == strand_halt_pkg::ST_RUNNING) softint_q[strand_halt_pkg::SOFTINT_SM_BIT] <= 1'b0;
      if (hyper_set) hintp_q <= 1'b1;
      else if (intr_pending && state_q == strand_halt_pkg::ST_RUNNING) hintp_q <= 1'b0;
    end
  end

  // Read data: sleep register always zero, tick reads low bits forced
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 64'h0;
      rvalid_q <= 1'b0;
      stick_rdata_q <= 64'h0;
    end else begin
      rvalid_q <= hpr_rd;
      rdata_q <= cmp_rd ? {int_dis_q, cmp_val_q} : strand_halt_pkg::SLEEP_REQ_RESET;
      if (stick_rd) begin
        stick_rdata_q <= {1'b0, stick_cnt[62:7], strand_halt_pkg::TICK_LOW_ONES};
      end
    end
  end

  // Status outputs, all from flip-flops
  assign strand_state = state_q;
  assign issue_en = issue_q;
  assign resume_valid = resume_q;
  assign next_instruction_address = npc_q;
  assign softint = softint_q;
  assign hyper_pending = hintp_q;
  assign tick_cmp_reg = {int_dis_q, cmp_val_q};
  assign hpr_rdata = rdata_q;
  assign hpr_rvalid = rvalid_q;
  assign stick_rdata = stick_rdata_q;
endmodule : strand_halt_wake

// ==== verification/strand_halt_checker.sv ====
// Port assertions for the strand halt and wake block
`timescale 1ns/1ps
module strand_halt_checker (
  // Watched ports
  input wire logic mclk, rst_b, hpr_wr, hpr_rd, stick_rd, tick_match, park_req, intr_pending,
  input wire logic xstrand_intr, vector_intr, external_reset_request, error_event, hyper_pending,
  input wire logic single_step_mode, disable_overlap_mode, hpr_rvalid, issue_en, resume_valid,
  input wire logic [4:0] hpr_addr,
  input wire logic [62:0] stick_cnt,
  input wire logic [63:0] hpr_rdata, stick_rdata,
  input wire logic [1:0] strand_state,
  input wire logic [16:0] softint
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Decoded wake, blocking and state conditions
  wire logic wk = xstrand_intr | vector_intr | external_reset_request | error_event;
  wire logic md = single_step_mode | disable_overlap_mode;
  wire logic blk = wk | md | intr_pending | tick_match | hyper_pending | (|softint);
  wire logic a1e = hpr_addr == strand_halt_pkg::SLEEP_REQ_ADDR;
  wire logic run = strand_state == 2'h2;
  wire logic hlt = strand_state == 2'h3;
  wire logic [55:0] hi = stick_cnt[62:7];
  sequence s_wake; hlt ##1 run; endsequence
  a_halt_entry: assert property (run && hpr_wr && a1e && !blk |=> hlt)
    else $error("halt missed");
  a_halt_refused: assert property (run && hpr_wr && a1e && blk |=> run)
    else $error("halt not refused");
  a_sleep_zero: assert property (hpr_rd && a1e |=> hpr_rvalid && hpr_rdata == 64'h0)
    else $error("sleep read not zero");
  a_tick_ones: assert property (stick_rd |=> stick_rdata == {1'h0, $past(hi), 7'h7f})
    else $error("tick read wrong");
  a_wake_source: assert property (hlt && wk |=> run)
    else $error("no wake");
  a_resume_pulse: assert property (s_wake |-> resume_valid)
    else $error("no resume");
  a_halt_idle: assert property (hlt |-> !issue_en)
    else $error("halted strand issues");
  a_park_path: assert property (hlt && park_req |=> run ##1 strand_state == 2'h1)
    else $error("park path wrong");
  a_tick_wake: assert property (hlt && tick_match |-> ##[1:2] run)
    else $error("tick did not wake");
  a_mode_wake: assert property (hlt && $rose(single_step_mode) |=> run)
    else $error("mode did not wake");
endmodule : strand_halt_checker
bind strand_halt_wake strand_halt_checker u_chk (.*);

// ==== verification/wake_src_model.sv ====
// Far side: other strands and error sources raising wake events
`timescale 1ns/1ps
module wake_src_model (
  // Clock and command
  input wire logic mclk,
  input wire logic [3:0] req,
  // Wake lines
  output logic xstrand_intr, vector_intr, external_reset_request, error_event
);
  // Registered copy of each command bit, held as long as the command bit is held
  always_ff @(posedge mclk) begin
    {error_event, external_reset_request, vector_intr, xstrand_intr} <= req;
  end
endmodule : wake_src_model

// ==== verification/tb.sv ====
// Self-checking testbench for the strand halt and wake block
`timescale 1ns/1ps
module tb;
  logic mclk = 0, rst_b = 0, hpr_wr = 0, hpr_rd = 0, stick_rd = 0, tick_match = 0;
  logic strand_enable = 0, park_req = 0, intr_pending = 0, single_step_mode, disable_overlap_mode;
  logic xstrand_intr, vector_intr, external_reset_request, error_event;
  logic hpr_rvalid, issue_en, resume_valid, hyper_pending;
  logic [1:0] strand_state, modes = 0;
  logic [3:0] req = 0;
  logic [4:0] hpr_addr = 0;
  logic [16:0] softint;
  logic [62:0] stick_cnt = 0;
  logic [63:0] hpr_wdata = 0, halt_npc = 0, hpr_rdata, stick_rdata, next_instruction_address, tick_cmp_reg;
  int mismatches = 0, cmp_count = 0;
  localparam logic [4:0] SLP = strand_halt_pkg::SLEEP_REQ_ADDR, CMP = strand_halt_pkg::TICK_CMP_ADDR;
  localparam logic [1:0] DIS = 2'h0, PRK = 2'h1, RUN = 2'h2, HLT = 2'h3;
  // Clock, mode lines, design and far side
  initial forever #2.5 mclk = ~mclk;
  assign {disable_overlap_mode, single_step_mode} = modes;
  strand_halt_wake u_dut (.*);
  wake_src_model u_src (.*);
  task automatic chk(string n, logic [64:0] s, logic [64:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task automatic st(logic [1:0] e);
    chk("state", strand_state, e);
  endtask : st
  task automatic pulse(ref logic s);
    s = 1;
    cyc(1);
    s = 0;
  endtask : pulse
  task automatic hw(logic [4:0] a, logic [63:0] d);
    hpr_addr = a;
    hpr_wdata = d;
    halt_npc = d;
    cyc(1);
    pulse(hpr_wr);
  endtask : hw
  task automatic t_reset;
    st(DIS);
    chk("cmp", tick_cmp_reg, strand_halt_pkg::TICK_CMP_RESET);
    hw(SLP, 64'h0);
    st(DIS);
    strand_enable = 1;
    cyc(1);
    st(RUN);
    for (int i = 0; i < 2; i++) begin
      hpr_addr = i ? SLP : 5'h05;
      cyc(1);
      pulse(hpr_rd);
      chk("rd", {hpr_rvalid, hpr_rdata}, 65'h1_0000_0000_0000_0000);
    end
    $display("reset test done");
  endtask : t_reset
  task automatic t_wake;
    for (int k = 0; k < 4; k++) begin
      hw(SLP, 64'h1000 + k);
      cyc(2);
      st(HLT);
      chk("issue", issue_en, 1'h0);
      chk("npc", next_instruction_address, 64'h1000 + k);
      req = 4'h1 << k;
      cyc(1);
      req = 4'h0;
      cyc(1);
      st(RUN);
      chk("resume", resume_valid, 1'h1);
      cyc(1);
      chk("resume end", resume_valid, 1'h0);
    end
    $display("wake test done");
  endtask : t_wake
  task automatic t_mode;
    intr_pending = 1;
    hw(SLP, 64'h0);
    intr_pending = 0;
    st(RUN);
    for (int m = 1; m < 3; m++) begin
      modes = 2'(m);
      hw(SLP, 64'h0);
      st(RUN);
      modes = 2'h0;
      hw(SLP, 64'h0);
      modes = 2'(m);
      cyc(1);
      st(RUN);
      modes = 2'h0;
      cyc(1);
    end
    $display("mode test done");
  endtask : t_mode
  task automatic t_tick;
    stick_cnt = 63'h1234_5678_9abc_def0;
    pulse(stick_rd);
    chk("stick", stick_rdata, {1'h0, stick_cnt[62:7], 7'h7f});
    hw(SLP, 64'h0);
    pulse(tick_match);
    cyc(1);
    st(RUN);
    hw(SLP, 64'h0);
    st(RUN);
    pulse(intr_pending);
    stick_cnt = 63'h0;
    hw(CMP, 64'h155);
    chk("cmp", tick_cmp_reg, 64'h155);
    hw(SLP, 64'h0);
    stick_cnt = 63'h17f;
    cyc(3);
    chk("hint", {strand_state, hyper_pending}, {RUN, 1'h1});
    chk("softint", softint, 17'h10000);
    hw(SLP, 64'h0);
    st(RUN);
    hw(CMP, 64'h8000_0000_0000_0155);
    pulse(intr_pending);
    $display("tick test done");
  endtask : t_tick
  task automatic t_park;
    hw(SLP, 64'h0);
    park_req = 1;
    cyc(1);
    st(RUN);
    cyc(1);
    st(PRK);
    park_req = 0;
    cyc(1);
    st(RUN);
    $display("park test done");
  endtask : t_park
  task automatic summarize;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // Main sequence and watchdog
  initial begin
    cyc(12);
    rst_b = 1;
    cyc(1);
    t_reset;
    t_wake;
    t_mode;
    t_tick;
    t_park;
    summarize;
  end
  initial begin
    #5000;
    mismatches++;
    summarize;
  end
endmodule : tb
